/* File: pss_defs.vh */
// register offsets, field positions and reset values of the status/result bank
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

`define PSS_ADDR_W          8
`define PSS_OFF_INT_SRC     8'h25
`define PSS_OFF_FIFO_STAT   8'h26
`define PSS_OFF_SAMPLE_FLG  8'h27
`define PSS_OFF_PRESS_LOW   8'h28
`define PSS_OFF_PRESS_MID   8'h29
`define PSS_OFF_PRESS_HIGH  8'h2a
`define PSS_OFF_TEMP_LOW    8'h2b
`define PSS_OFF_TEMP_HIGH   8'h2c
`define PSS_OFF_FILT_RESET  8'h33
`define PSS_OFF_FIFO_CTRL   8'h14

`define PSS_BIT_BOOT        7
`define PSS_BIT_INT_ACTIVE  2
`define PSS_BIT_LOW_EVENT   1
`define PSS_BIT_HIGH_EVENT  0
`define PSS_BIT_WATERMARK   7
`define PSS_BIT_OVERWRITTEN 6
`define PSS_BIT_T_OVERRUN   5
`define PSS_BIT_P_OVERRUN   4
`define PSS_BIT_T_READY     1
`define PSS_BIT_P_READY     0

`define PSS_FIFO_FULL       6'h20
`define PSS_OFFSET_SHIFT    8
`define PSS_READ_ZERO       8'h00

`endif

/* File: pss_host.sv */
// host model issuing single-byte register reads
`timescale 1ns/1ps
// ====================================================
// host
module pss_host
(
	input  wire       i_clock,
	input  wire [7:0] i_rd_data,
	output reg        o_rd_en,
	output reg  [7:0] o_rd_addr
);
	initial
	begin
		o_rd_en = 1'b0;
		o_rd_addr = 8'hff;
	end
	// one strobe per byte, address dropped to its inverse after
	task rd(input [7:0] a, output [7:0] d);
	begin
		@(negedge i_clock);
		o_rd_en = 1'b1;
		o_rd_addr = a;
		@(negedge i_clock);
		o_rd_en = 1'b0;
		o_rd_addr = ~a;
		d = i_rd_data;
	end
	endtask
endmodule // pss_host

/* File: pss_status_regs.v */
// status and result register bank of a barometric pressure sensor
`timescale 1ns/1ps
// =====================================================================
// What this block does
// R1: bit 7 shows boot in progress
// R2: interrupt-active set when any event raised
// R3: bit 1 reports low pressure event
// R4: bit 0 reports high pressure event
// R5: watermark flag when fill level reaches watermark
// R6: overwritten flag when full and sample lost
// R7: six-bit unread sample count, 32 means full
// R8: temperature overrun when unread sample replaced
// R9: pressure overrun when unread sample replaced
// R10: temperature ready flag on new sample
// R11: pressure ready flag on new sample
// R12: sample flags refreshed each output period
// R13: 24-bit pressure over 28h to 2Ah
// R14: pressure result is measured minus offset
// R15: offset scaled by 256 before subtract
// R16: 16-bit temperature at 2Bh and 2Ch
// R17: reading 33h resets the lowpass filter
// R18: watermark level is five bits at 14h
// R19: multi-byte results held coherent during reads
module pss_status_regs
(
	input  wire        i_clock,
	input  wire        i_rstn,
	input  wire        i_rd_en,
	input  wire [7:0]  i_rd_addr,
	output reg  [7:0]  o_rd_data,
	input  wire        i_boot_busy,
	input  wire        i_low_pressure_event,
	input  wire        i_high_pressure_event,
	input  wire        i_pressure_lowpass_filter,
	input  wire [4:0]  i_watermark_level,
	input  wire [5:0]  i_fifo_fill_level,
	input  wire        i_fifo_overwritten,
	input  wire        i_output_rate_tick,
	input  wire        i_press_valid,
	input  wire [23:0] i_press_measured,
	input  wire        i_temp_valid,
	input  wire [15:0] i_temp_measured,
	input  wire [15:0] i_pressure_offset,
	output wire        o_filter_reset
);
`include "pss_defs.vh"

// =====================================================================
// register state
reg         press_pend_reg;
reg         temp_pend_reg;
reg         press_ready_reg;
reg         temp_ready_reg;
reg         press_overrun_reg;
reg         temp_overrun_reg;
reg  [23:0] press_result_reg;
reg  [15:0] temp_result_reg;
reg  [23:0] press_hold_reg;
reg  [15:0] temp_hold_reg;
reg         press_lock_reg;
reg         temp_lock_reg;

// =====================================================================
// next values
reg         press_pend_next;
reg         temp_pend_next;
reg         press_ready_next;
reg         temp_ready_next;
reg         press_overrun_next;
reg         temp_overrun_next;
reg  [23:0] press_hold_next;
reg  [15:0] temp_hold_next;
reg         press_lock_next;
reg         temp_lock_next;
reg  [7:0]  rd_data_next;

wire [23:0] offset_scaled;
wire [23:0] press_diff;
wire        rd_p_low;
wire        rd_p_high;
wire        rd_t_low;
wire        rd_t_high;
wire        watermark_hit;
wire        any_event;

// =====================================================================
// pressure arithmetic
assign offset_scaled = {i_pressure_offset, 8'h00}; // R15
assign press_diff    = i_press_measured - offset_scaled; // R14

// =====================================================================
// read decode
assign rd_p_low  = i_rd_en && (i_rd_addr == `PSS_OFF_PRESS_LOW);
assign rd_p_high = i_rd_en && (i_rd_addr == `PSS_OFF_PRESS_HIGH);
assign rd_t_low  = i_rd_en && (i_rd_addr == `PSS_OFF_TEMP_LOW);
assign rd_t_high = i_rd_en && (i_rd_addr == `PSS_OFF_TEMP_HIGH);
assign o_filter_reset = i_rd_en && i_pressure_lowpass_filter
	&& (i_rd_addr == `PSS_OFF_FILT_RESET); // R17

// equal-or-above reading taken for the watermark flag
assign watermark_hit = (i_fifo_fill_level >= {1'b0, i_watermark_level}); // R5 R18
assign any_event   = i_low_pressure_event || i_high_pressure_event; // R2

// =====================================================================
// pressure pending sample, a tick consumes it
always @*
begin
	press_pend_next = press_pend_reg;
	if (i_output_rate_tick)
		press_pend_next = 1'b0;
	else if (i_press_valid)
		press_pend_next = 1'b1;
end

// =====================================================================
// temperature pending sample, a tick consumes it
always @*
begin
	temp_pend_next = temp_pend_reg;
	if (i_output_rate_tick)
		temp_pend_next = 1'b0;
	else if (i_temp_valid)
		temp_pend_next = 1'b1;
end

// =====================================================================
// pressure flags, tick wins over a high byte read
always @*
begin
	press_ready_next   = press_ready_reg;
	press_overrun_next = press_overrun_reg;
	if (i_output_rate_tick) // R12
	begin
		if (press_pend_reg || i_press_valid)
		begin
			press_overrun_next = press_ready_reg; // R9
			press_ready_next   = 1'b1; // R11
		end
	end
	else if (rd_p_high)
	begin
		press_ready_next   = 1'b0;
		press_overrun_next = 1'b0;
	end
end

// =====================================================================
// temperature flags, tick wins over a high byte read
always @*
begin
	temp_ready_next   = temp_ready_reg;
	temp_overrun_next = temp_overrun_reg;
	if (i_output_rate_tick) // R12
	begin
		if (temp_pend_reg || i_temp_valid)
		begin
			temp_overrun_next = temp_ready_reg; // R8
			temp_ready_next   = 1'b1; // R10
		end
	end
	else if (rd_t_high)
	begin
		temp_ready_next   = 1'b0;
		temp_overrun_next = 1'b0;
	end
end

// =====================================================================
// sample and flag registers
always @(posedge i_clock)
begin
	if (!i_rstn)
	begin
		press_pend_reg    <= 1'b0;
		temp_pend_reg     <= 1'b0;
		press_ready_reg   <= 1'b0;
		temp_ready_reg    <= 1'b0;
		press_overrun_reg <= 1'b0;
		temp_overrun_reg  <= 1'b0;
		press_result_reg  <= 24'h000000;
		temp_result_reg   <= 16'h0000;
	end
	else
	begin
		press_pend_reg    <= press_pend_next;
		temp_pend_reg     <= temp_pend_next;
		press_ready_reg   <= press_ready_next;
		temp_ready_reg    <= temp_ready_next;
		press_overrun_reg <= press_overrun_next;
		temp_overrun_reg  <= temp_overrun_next;
		if (i_press_valid)
			press_result_reg <= press_diff; // R13 R14
		if (i_temp_valid)
			temp_result_reg <= i_temp_measured; // R16
	end
end

// =====================================================================
// pressure snapshot for coherent multi-byte reads
always @*
begin
	press_hold_next = press_hold_reg;
	press_lock_next = press_lock_reg;
	if (rd_p_low)
	begin
		press_hold_next = press_result_reg; // R19
		press_lock_next = 1'b1;
	end
	else if (rd_p_high)
		press_lock_next = 1'b0;
end

// =====================================================================
// temperature snapshot for coherent multi-byte reads
always @*
begin
	temp_hold_next = temp_hold_reg;
	temp_lock_next = temp_lock_reg;
	if (rd_t_low)
	begin
		temp_hold_next = temp_result_reg; // R19
		temp_lock_next = 1'b1;
	end
	else if (rd_t_high)
		temp_lock_next = 1'b0;
end

// =====================================================================
// snapshot registers
always @(posedge i_clock)
begin
	if (!i_rstn)
	begin
		press_hold_reg <= 24'h000000;
		temp_hold_reg  <= 16'h0000;
		press_lock_reg <= 1'b0;
		temp_lock_reg  <= 1'b0;
	end
	else
	begin
		press_hold_reg <= press_hold_next;
		temp_hold_reg  <= temp_hold_next;
		press_lock_reg <= press_lock_next;
		temp_lock_reg  <= temp_lock_next;
	end
end

// =====================================================================
// read data mux
always @*
begin
	rd_data_next = `PSS_READ_ZERO;
	case (i_rd_addr)
		`PSS_OFF_INT_SRC:
		begin
			rd_data_next[`PSS_BIT_BOOT]       = i_boot_busy; // R1
			rd_data_next[`PSS_BIT_INT_ACTIVE] = any_event; // R2
			rd_data_next[`PSS_BIT_LOW_EVENT]  = i_low_pressure_event; // R3
			rd_data_next[`PSS_BIT_HIGH_EVENT] = i_high_pressure_event; // R4
		end
		`PSS_OFF_FIFO_STAT:
		begin
			rd_data_next[`PSS_BIT_WATERMARK] = watermark_hit; // R5
			rd_data_next[`PSS_BIT_OVERWRITTEN] = i_fifo_overwritten
				&& (i_fifo_fill_level == `PSS_FIFO_FULL); // R6
			rd_data_next[5:0] = i_fifo_fill_level; // R7
		end
		`PSS_OFF_SAMPLE_FLG:
		begin
			rd_data_next[`PSS_BIT_T_OVERRUN] = temp_overrun_reg; // R8
			rd_data_next[`PSS_BIT_P_OVERRUN] = press_overrun_reg; // R9
			rd_data_next[`PSS_BIT_T_READY]   = temp_ready_reg; // R10
			rd_data_next[`PSS_BIT_P_READY]   = press_ready_reg; // R11
		end
		`PSS_OFF_PRESS_LOW:
			rd_data_next = press_result_reg[7:0]; // R13
		`PSS_OFF_PRESS_MID:
			rd_data_next = press_lock_reg ? press_hold_reg[15:8]
				: press_result_reg[15:8]; // R19
		`PSS_OFF_PRESS_HIGH:
			rd_data_next = press_lock_reg ? press_hold_reg[23:16]
				: press_result_reg[23:16]; // R19
		`PSS_OFF_TEMP_LOW:
			rd_data_next = temp_result_reg[7:0]; // R16
		`PSS_OFF_TEMP_HIGH:
			rd_data_next = temp_lock_reg ? temp_hold_reg[15:8]
				: temp_result_reg[15:8]; // R19
		default:
			rd_data_next = `PSS_READ_ZERO;
	endcase
end

// =====================================================================
// read data register, holds until the next read
always @(posedge i_clock)
begin
	if (!i_rstn)
		o_rd_data <= `PSS_READ_ZERO;
	else if (i_rd_en)
		o_rd_data <= rd_data_next;
end

endmodule // pss_status_regs

/* File: pss_status_regs_properties.sv */
// assertion checker of the status/result register bank
`timescale 1ns/1ps
// ====================================================
// checker
module pss_status_regs_chk
(
	input wire       i_clock,
	input wire       i_rstn,
	input wire       i_rd_en,
	input wire [7:0] i_rd_addr,
	input wire [7:0] o_rd_data,
	input wire       i_boot_busy,
	input wire       i_low_pressure_event,
	input wire       i_high_pressure_event,
	input wire       i_pressure_lowpass_filter,
	input wire [4:0] i_watermark_level,
	input wire [5:0] i_fifo_fill_level,
	input wire       i_fifo_overwritten,
	input wire       o_filter_reset
);
	wire       lo = i_low_pressure_event;
	wire       hi = i_high_pressure_event;
	wire       flt = i_pressure_lowpass_filter;
	wire       rd33 = i_rd_en && i_rd_addr == 8'h33;
	wire [5:0] fl = i_fifo_fill_level;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	sequence s_rd(a);
		i_rd_en && i_rd_addr == a;
	endsequence
	AST_BOOT: assert property (s_rd(8'h25)
		|=> o_rd_data[7] == $past(i_boot_busy)) else $error("boot flag");
	AST_IRQ: assert property (s_rd(8'h25)
		|=> o_rd_data[6:0] == {4'h0, $past(lo) | $past(hi), $past(lo), $past(hi)})
		else $error("event flags");
	AST_FILL: assert property (s_rd(8'h26)
		|=> o_rd_data[5:0] == $past(fl)) else $error("fill level");
	AST_WATERMARK: assert property (s_rd(8'h26)
		|=> o_rd_data[7] == ($past(fl) >= {1'b0, $past(i_watermark_level)}))
		else $error("watermark flag");
	AST_OVERWRITE: assert property (s_rd(8'h26)
		|=> o_rd_data[6] == ($past(i_fifo_overwritten) && $past(fl) == 6'h20))
		else $error("overwritten flag");
	AST_FRES: assert property (rd33 && flt |-> o_filter_reset)
		else $error("filter reset missing");
	AST_FCAUSE: assert property (o_filter_reset |-> rd33 && flt)
		else $error("filter reset spurious");
	AST_HOLD: assert property (!i_rd_en |=> $stable(o_rd_data))
		else $error("read data moved");
endmodule // pss_status_regs_chk
bind pss_status_regs pss_status_regs_chk i_pss_status_regs_chk (.*);

/* File: pss_status_regs_tb_top.sv */
// self-checking bench of the status/result register bank
`timescale 1ns/1ps
// ====================================================
// bench top
module pss_status_regs_tb_top;
	reg         i_clock, i_rstn, boot, lo, hi, filt, ovw, tick, pv, tv;
	reg  [4:0]  wml;
	reg  [5:0]  fill;
	reg  [23:0] pm;
	reg  [15:0] tm, off;
	reg  [7:0]  d;
	wire [7:0]  rdat, addr;
	wire        en;
	integer     n_fail, cmp_count;
	always #2.5 i_clock = ~i_clock;
	pss_status_regs i_pss_status_regs (.i_clock(i_clock), .i_rstn(i_rstn),
		.i_rd_en(en), .i_rd_addr(addr), .o_rd_data(rdat), .i_boot_busy(boot),
		.i_low_pressure_event(lo), .i_high_pressure_event(hi),
		.i_pressure_lowpass_filter(filt), .i_watermark_level(wml),
		.i_fifo_fill_level(fill), .i_fifo_overwritten(ovw),
		.i_output_rate_tick(tick), .i_press_valid(pv), .i_press_measured(pm),
		.i_temp_valid(tv), .i_temp_measured(tm), .i_pressure_offset(off),
		.o_filter_reset());
	pss_host i_pss_host (.i_clock(i_clock), .i_rd_data(rdat), .o_rd_en(en),
		.o_rd_addr(addr));
	task chk(input [7:0] a, e, g);
	begin
		cmp_count = cmp_count + 1;
		if (g !== e)
		begin
			n_fail = n_fail + 1;
			$display("ERROR reg %h expected %h seen %h", a, e, g);
		end
	end
	endtask
	task rc(input [7:0] a, e);
	begin
		i_pss_host.rd(a, d);
		chk(a, e, d);
	end
	endtask
	task smp(input [23:0] p, input [15:0] t);
	begin
		@(negedge i_clock);
		{pm, tm, pv, tv, tick} = {p, t, 3'h7};
		@(negedge i_clock);
		{pv, tv, tick} = 3'h0;
	end
	endtask
	task stop_test;
	begin
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	// ====================================================
	// scenarios
	task t_int;
	begin
		{boot, lo} = 2'h3;
		rc(8'h25, 8'h86);
		{boot, lo, hi} = 3'h1;
		rc(8'h25, 8'h05);
		rc(8'h30, 8'h00);
	end
	endtask
	task t_fifo;
	begin
		{wml, fill} = {5'h05, 6'h05};
		rc(8'h26, 8'h85);
		fill = 6'h04;
		rc(8'h26, 8'h04);
		{ovw, fill} = {1'b1, 6'h1f};
		rc(8'h26, 8'h9f);
		fill = 6'h20;
		rc(8'h26, 8'he0);
	end
	endtask
	task t_press;
	begin
		filt = 1'b1;
		i_pss_host.rd(8'h33, d);
		off = 16'h0001;
		smp(24'h123456, 16'hbeef);
		rc(8'h27, 8'h03);
		rc(8'h28, 8'h56);
		smp(24'h000000, 16'h8001);
		rc(8'h27, 8'h33);
		rc(8'h29, 8'h33);
		rc(8'h2a, 8'h12);
		rc(8'h27, 8'h22);
		rc(8'h2b, 8'h01);
		rc(8'h2c, 8'h80);
		rc(8'h28, 8'h00);
		rc(8'h29, 8'hff);
		rc(8'h2a, 8'hff);
		@(negedge i_clock);
		pv = 1'b1;
		@(negedge i_clock);
		pv = 1'b0;
		rc(8'h27, 8'h00);
		smp(24'h000000, 16'h0000);
		rc(8'h27, 8'h03);
		@(negedge i_clock);
		tick = 1'b1;
		@(negedge i_clock);
		tick = 1'b0;
		rc(8'h27, 8'h03);
	end
	endtask
	initial
	begin
		{i_clock, i_rstn, boot, lo, hi, filt, ovw, tick, pv, tv} = 10'h0;
		{wml, fill, pm, tm, off} = 67'h0;
		{n_fail, cmp_count} = 64'h0;
		repeat (3) @(negedge i_clock);
		i_rstn = 1'b1;
		rc(8'h27, 8'h00);
		t_int;
		t_fifo;
		t_press;
		stop_test;
	end
	initial
	begin
		#5000;
		n_fail = n_fail + 1;
		stop_test;
	end
endmodule // pss_status_regs_tb_top
